// ==== rtl/brake_seq_pkg.sv ====
// Constants, types and carriers shared by the start/stop braking sequencer
`default_nettype none
package brake_seq_pkg;
  // ***********************************************************
  // Parameter codes
  // ***********************************************************
  localparam logic [1:0] BRK_SEL_OFF = 2'h0;
  localparam logic [1:0] BRK_SEL_ON = 2'h1;
  localparam logic [1:0] BRK_SEL_FREQ = 2'h2;
  localparam logic [1:0] BRK_MODE_DC = 2'h0;
  localparam logic [1:0] BRK_MODE_SPEED = 2'h1;
  localparam logic [1:0] BRK_MODE_POS = 2'h2;
  localparam logic [7:0] METHOD_SLV_ZERO = 8'h09;
  localparam logic [7:0] METHOD_VEC_SENSOR = 8'h0A;
  localparam logic [1:0] STOP_DECEL = 2'h0;
  localparam logic [1:0] STOP_COAST = 2'h1;
  localparam logic [1:0] RESTART_ZERO = 2'h0;
  localparam logic [1:0] RESTART_MATCH = 2'h1;
  localparam logic [1:0] RESTART_PULLIN = 2'h2;
  localparam logic [7:0] COAST_INPUT_FUNC = 8'h20;
  // ***********************************************************
  // Field widths and limits
  // ***********************************************************
  localparam int DUR_W = 10;
  localparam logic [DUR_W-1:0] DUR_MAX = 10'h258;
  localparam int FREQ_W = 16;
  localparam logic [6:0] FORCE_NONE = 7'h00;
  localparam logic [6:0] CARRIER_DROP_PCT = 7'h32;
  // ***********************************************************
  // Timing
  // ***********************************************************
  localparam longint CLK_HZ = 10000000;
  localparam longint TICK_MS = 100;
  localparam int TICK_CYCLES = int'((CLK_HZ * TICK_MS) / 1000);
  // ***********************************************************
  // Types
  // ***********************************************************
  typedef struct packed {
    logic [7:0] control_method_sel;
    logic [7:0] vector_variant_sel;
    logic [1:0] internal_brake_sel;
    logic [1:0] brake_type_sel;
    logic [FREQ_W-1:0] brake_threshold_freq;
    logic [6:0] brake_force_pct;
    logic [DUR_W-1:0] stop_brake_duration;
    logic [DUR_W-1:0] start_brake_duration;
    logic [1:0] stop_method_sel;
    logic [1:0] restart_after_coast_sel;
  } drive_cfg_t;
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_START_LOCK = 3'h1,
    ST_RUN = 3'h2,
    ST_DECEL = 3'h3,
    ST_STOP_BRAKE = 3'h4,
    ST_COAST = 3'h5,
    ST_FREQ_BRAKE = 3'h6
  } seq_state_t;
  typedef struct packed {
    logic output_en;
    logic servo_lock;
    logic lock_position;
    logic dc_brake;
    logic decel;
    logic run_normal;
    logic carrier_reduce;
    logic [1:0] restart_mode;
  } drive_out_t;
endpackage : brake_seq_pkg
`default_nettype wire

// ==== rtl/interval_timer.sv ====
// Tick divider and down-counter timing braking intervals in 0.1 s steps
`default_nettype none
module interval_timer #(
  parameter int TICK_CYCLES = brake_seq_pkg::TICK_CYCLES,
  parameter int CNT_W = brake_seq_pkg::DUR_W
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Control
  input wire logic i_load,
  input wire logic [CNT_W-1:0] i_load_val,
  // Status
  output logic o_expired
);
  import brake_seq_pkg::*;
  localparam int PRE_W = $clog2(TICK_CYCLES + 1);
  localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);
  // Refused at elaboration: a zero tick or width cannot time anything
  if (TICK_CYCLES < 1 || CNT_W < 1)
  begin : g_bad_params
    $error("interval_timer: bad parameters");
  end
  typedef struct packed {
    logic [PRE_W-1:0] pre;
    logic [CNT_W-1:0] cnt;
  } timer_state_t;
  timer_state_t s_q;
  timer_state_t s_d;
  always_comb
  begin
    s_d = s_q;
    if (i_load)
    begin
      // Reload also realigns the tick so every interval is whole
      s_d.pre = '0;
      s_d.cnt = i_load_val;
    end
    else if (s_q.cnt != '0)
    begin
      if (s_q.pre == PRE_LAST)
      begin
        s_d.pre = '0;
        s_d.cnt = s_q.cnt - CNT_W'(1);
      end
      else
      begin
        s_d.pre = s_q.pre + PRE_W'(1);
      end
    end
  end
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
  assign o_expired = (s_q.cnt == '0);
endmodule : interval_timer
`default_nettype wire

// ==== rtl/start_stop_braking_sequencer.sv ====
// Start/stop sequencer: start servo-lock, stop method, DC braking choices
`default_nettype none
module start_stop_braking_sequencer #(
  parameter int TICK_CYCLES = brake_seq_pkg::TICK_CYCLES
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Operator command pins
  input wire logic i_run_cmd,
  input wire logic i_coast_stop_input,
  // Parameter settings
  input wire brake_seq_pkg::drive_cfg_t i_cfg,
  // Frequency state from the drive core
  input wire logic [brake_seq_pkg::FREQ_W-1:0] i_freq_cmd,
  input wire logic [brake_seq_pkg::FREQ_W-1:0] i_out_freq,
  // Power stage requests
  output brake_seq_pkg::drive_out_t o_drive,
  output brake_seq_pkg::seq_state_t o_state
);
  import brake_seq_pkg::*;
  // Refused at elaboration: the interval timer needs a tick of one cycle or more
  if (TICK_CYCLES < 1)
  begin : g_bad_tick
    $error("start_stop_braking_sequencer: TICK_CYCLES must be positive");
  end
  // ***********************************************************
  // State
  // ***********************************************************
  typedef struct packed {
    logic [2:0] run_sync;
    logic [2:0] coast_sync;
    logic run;
    logic coast;
    seq_state_t state;
    logic coasted;
    logic freq_brake_armed;
    drive_out_t out;
  } seq_reg_t;
  seq_reg_t s_q;
  seq_reg_t s_d;
  logic timer_load;
  logic [DUR_W-1:0] timer_val;
  logic timer_expired;
  // ***********************************************************
  // Setting decode
  // ***********************************************************
  logic speed_ok;
  logic pos_ok;
  logic [1:0] eff_mode;
  logic force_ok;
  logic [DUR_W-1:0] start_dur;
  logic [DUR_W-1:0] stop_dur;
  logic start_lock_en;
  logic stop_brake_en;
  logic freq_brake_en;
  logic below_thr;
  logic cmd_below_thr;
  logic cut_request;
  always_comb
  begin
    speed_ok = (i_cfg.control_method_sel == METHOD_SLV_ZERO) ||
               (i_cfg.control_method_sel == METHOD_VEC_SENSOR);
    pos_ok = (i_cfg.control_method_sel == METHOD_VEC_SENSOR);
    // A lock the method cannot serve degrades to plain DC braking
    if ((i_cfg.brake_type_sel == BRK_MODE_SPEED && speed_ok) ||
        (i_cfg.brake_type_sel == BRK_MODE_POS && pos_ok))
    begin
      eff_mode = i_cfg.brake_type_sel;
    end
    else
    begin
      eff_mode = BRK_MODE_DC;
    end
    force_ok = (i_cfg.brake_force_pct != FORCE_NONE);
    // Settings past the upper limit are held at it
    start_dur = (i_cfg.start_brake_duration > DUR_MAX) ? DUR_MAX : i_cfg.start_brake_duration;
    stop_dur = (i_cfg.stop_brake_duration > DUR_MAX) ? DUR_MAX : i_cfg.stop_brake_duration;
    start_lock_en = (i_cfg.internal_brake_sel == BRK_SEL_ON) &&
                    (eff_mode == BRK_MODE_SPEED || eff_mode == BRK_MODE_POS) &&
                    (start_dur != '0) && force_ok;
    stop_brake_en = (i_cfg.internal_brake_sel == BRK_SEL_ON) && (eff_mode == BRK_MODE_DC) &&
                    (stop_dur != '0) && force_ok;
    freq_brake_en = (i_cfg.internal_brake_sel == BRK_SEL_FREQ) &&
                    (i_cfg.brake_type_sel == BRK_MODE_SPEED || i_cfg.brake_type_sel == BRK_MODE_POS) &&
                    (i_cfg.brake_threshold_freq != '0) && (stop_dur != '0) && force_ok;
    below_thr = (i_out_freq <= i_cfg.brake_threshold_freq);
    cmd_below_thr = (i_freq_cmd <= i_cfg.brake_threshold_freq);
    // The coast terminal is wired by the operator to function 032
    cut_request = s_q.coast;
  end
  // ***********************************************************
  // Sequencer
  // ***********************************************************
  always_comb
  begin
    s_d = s_q;
    timer_load = 1'b0;
    timer_val = start_dur;
    // Three-stage pin synchronisers; a change counts once stages 2 and 3 agree
    s_d.run_sync = {s_q.run_sync[1:0], i_run_cmd};
    s_d.coast_sync = {s_q.coast_sync[1:0], i_coast_stop_input};
    if (s_q.run_sync[2] == s_q.run_sync[1])
    begin
      s_d.run = s_q.run_sync[2];
    end
    if (s_q.coast_sync[2] == s_q.coast_sync[1])
    begin
      s_d.coast = s_q.coast_sync[2];
    end
    unique case (s_q.state)
      ST_IDLE:
      begin
        if (s_q.run && !cut_request)
        begin
          if (start_lock_en)
          begin
            s_d.state = ST_START_LOCK;
            timer_load = 1'b1;
            timer_val = start_dur;
          end
          else
          begin
            s_d.state = ST_RUN;
          end
          s_d.freq_brake_armed = 1'b1;
        end
      end
      ST_START_LOCK:
      begin
        if (cut_request || !s_q.run)
        begin
          s_d.state = ST_COAST;
          s_d.coasted = 1'b1;
        end
        else if (timer_expired)
        begin
          s_d.state = ST_RUN;
        end
      end
      ST_RUN:
      begin
        if (cut_request || (!s_q.run && i_cfg.stop_method_sel == STOP_COAST))
        begin
          s_d.state = ST_COAST;
          s_d.coasted = 1'b1;
        end
        else if (!s_q.run)
        begin
          s_d.state = ST_DECEL;
        end
        else if (freq_brake_en && s_q.freq_brake_armed && below_thr && cmd_below_thr)
        begin
          s_d.state = ST_FREQ_BRAKE;
          s_d.freq_brake_armed = 1'b0;
          timer_load = 1'b1;
          timer_val = stop_dur;
        end
        else if (!cmd_below_thr)
        begin
          // Re-arm only once the command has left the braking band
          s_d.freq_brake_armed = 1'b1;
        end
      end
      ST_DECEL:
      begin
        if (cut_request)
        begin
          s_d.state = ST_COAST;
          s_d.coasted = 1'b1;
        end
        else if (s_q.run)
        begin
          s_d.state = ST_RUN;
        end
        else if (below_thr || i_out_freq == '0)
        begin
          if (stop_brake_en)
          begin
            s_d.state = ST_STOP_BRAKE;
            timer_load = 1'b1;
            timer_val = stop_dur;
          end
          else
          begin
            s_d.state = ST_IDLE;
          end
        end
      end
      ST_STOP_BRAKE:
      begin
        if (cut_request)
        begin
          s_d.state = ST_COAST;
          s_d.coasted = 1'b1;
        end
        else if (timer_expired)
        begin
          s_d.state = ST_IDLE;
        end
      end
      ST_COAST:
      begin
        if (!cut_request && s_q.run)
        begin
          s_d.state = ST_IDLE;
        end
        else if (!cut_request && !s_q.run)
        begin
          s_d.state = ST_IDLE;
        end
      end
      ST_FREQ_BRAKE:
      begin
        if (cut_request || !s_q.run)
        begin
          s_d.state = (i_cfg.stop_method_sel == STOP_COAST || cut_request) ? ST_COAST : ST_IDLE;
          s_d.coasted = (i_cfg.stop_method_sel == STOP_COAST) || cut_request;
        end
        else if (timer_expired)
        begin
          s_d.state = ST_RUN;
        end
      end
      default:
      begin
        s_d.state = ST_IDLE;
      end
    endcase
    // Restart mode is latched when a run leaves idle, then the coast mark is spent
    if (s_q.state == ST_IDLE && s_d.state != ST_IDLE)
    begin
      s_d.out.restart_mode = s_q.coasted ? i_cfg.restart_after_coast_sel : RESTART_ZERO;
      s_d.coasted = 1'b0;
    end
    s_d.out.output_en = (s_d.state != ST_IDLE) && (s_d.state != ST_COAST);
    s_d.out.servo_lock = (s_d.state == ST_START_LOCK);
    // Lock kind follows method and mode, no user setting of its own
    s_d.out.lock_position = (s_d.state == ST_START_LOCK) && (eff_mode == BRK_MODE_POS);
    s_d.out.dc_brake = (s_d.state == ST_STOP_BRAKE) || (s_d.state == ST_FREQ_BRAKE);
    s_d.out.decel = (s_d.state == ST_DECEL);
    s_d.out.run_normal = (s_d.state == ST_RUN);
    // Protective carrier drop is coarse: one force threshold, no taper
    s_d.out.carrier_reduce = (s_d.out.servo_lock || s_d.out.dc_brake) &&
                             (i_cfg.brake_force_pct >= CARRIER_DROP_PCT);
  end
  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end
  // ***********************************************************
  // Interval timer
  // ***********************************************************
  interval_timer #(
    .TICK_CYCLES(TICK_CYCLES),
    .CNT_W(DUR_W)
  ) u_timer (
    .i_mclk(i_mclk),
    .i_rst(i_rst),
    .i_load(timer_load),
    .i_load_val(timer_val),
    .o_expired(timer_expired)
  );
  assign o_drive = s_q.out;
  assign o_state = s_q.state;
endmodule : start_stop_braking_sequencer
`default_nettype wire

// ==== testbench/brake_seq_chk.sv ====
// Port assertions for the start/stop braking sequencer
`default_nettype none
module brake_seq_chk #(
  parameter int TICK_CYCLES = 8
) (
  // Clock and reset
  input wire logic i_mclk,
  input wire logic i_rst,
  // Watched ports
  input wire logic i_run_cmd,
  input wire logic i_coast_stop_input,
  input wire brake_seq_pkg::drive_cfg_t i_cfg,
  input wire logic [brake_seq_pkg::FREQ_W-1:0] i_freq_cmd,
  input wire logic [brake_seq_pkg::FREQ_W-1:0] i_out_freq,
  input wire brake_seq_pkg::drive_out_t o_drive,
  input wire brake_seq_pkg::seq_state_t o_state
);
  timeunit 1ns;
  timeprecision 1ns;
  import brake_seq_pkg::*;
  // ****************
  // Helpers
  // ****************
  // Wide enough for the longest start time at a full-size tick
  logic [31:0] lock_q;
  logic [31:0] lock_d;
  logic lockable;
  int lo;
  always_comb
  begin
    lock_d = (o_state == ST_START_LOCK) ? lock_q + 32'h00000001 : 32'h00000000;
    lockable = (i_cfg.brake_type_sel == BRK_MODE_SPEED && (i_cfg.control_method_sel == METHOD_SLV_ZERO
      || i_cfg.control_method_sel == METHOD_VEC_SENSOR))
      || (i_cfg.brake_type_sel == BRK_MODE_POS && i_cfg.control_method_sel == METHOD_VEC_SENSOR);
    // Start times past the upper limit are served at the limit
    lo = int'((i_cfg.start_brake_duration > DUR_MAX) ? DUR_MAX : i_cfg.start_brake_duration) * TICK_CYCLES;
  end
  always_ff @(posedge i_mclk)
  begin
    lock_q <= i_rst ? 32'h00000000 : lock_d;
  end
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);
  // ****************
  // Assertions
  // ****************
  a_lock_cfg_ok: assert property (
    o_state == ST_START_LOCK |-> i_cfg.internal_brake_sel == BRK_SEL_ON && lockable
    && i_cfg.start_brake_duration != 0 && i_cfg.brake_force_pct != FORCE_NONE)
    else $error("start lock without its settings");
  a_lock_outputs: assert property (
    o_state == ST_START_LOCK |-> o_drive.servo_lock && o_drive.output_en && !o_drive.run_normal)
    else $error("start lock outputs wrong");
  a_pos_lock_kind: assert property (
    o_state == ST_START_LOCK |-> o_drive.lock_position == (i_cfg.brake_type_sel == BRK_MODE_POS))
    else $error("lock kind wrong");
  a_lock_length: assert property (
    o_state == ST_RUN && $past(o_state) == ST_START_LOCK |-> lock_q >= lo && lock_q <= lo + 2)
    else $error("start lock length wrong");
  a_stop_dc_cfg: assert property (
    o_state == ST_STOP_BRAKE |-> o_drive.dc_brake && i_cfg.internal_brake_sel == BRK_SEL_ON && !lockable
    && i_cfg.stop_brake_duration != 0 && i_cfg.brake_force_pct != FORCE_NONE)
    else $error("stop braking without its settings");
  a_freq_dc_cfg: assert property (
    o_state == ST_FREQ_BRAKE |-> o_drive.dc_brake && i_cfg.internal_brake_sel == BRK_SEL_FREQ
    && i_cfg.brake_type_sel != BRK_MODE_DC && i_cfg.brake_threshold_freq != 0 && i_cfg.stop_brake_duration != 0)
    else $error("frequency braking without its settings");
  a_coast_cut: assert property (
    o_state == ST_COAST |-> !o_drive.output_en)
    else $error("output on while coasting");
  a_decel_ramp: assert property (
    $rose(o_state == ST_DECEL) |-> o_drive.decel && o_drive.output_en && i_cfg.stop_method_sel == STOP_DECEL)
    else $error("deceleration entry wrong");
  a_coast_input: assert property (
    i_coast_stop_input [*8] |-> o_state != ST_RUN && o_state != ST_START_LOCK)
    else $error("running with coast input high");
  a_carrier_drop: assert property (
    o_drive.carrier_reduce |-> (o_drive.servo_lock || o_drive.dc_brake)
    && i_cfg.brake_force_pct >= CARRIER_DROP_PCT)
    else $error("carrier drop without heavy braking");
endmodule : brake_seq_chk
bind start_stop_braking_sequencer brake_seq_chk #(.TICK_CYCLES(TICK_CYCLES)) chk_u (
  .i_mclk(i_mclk), .i_rst(i_rst), .i_run_cmd(i_run_cmd), .i_coast_stop_input(i_coast_stop_input),
  .i_cfg(i_cfg), .i_freq_cmd(i_freq_cmd), .i_out_freq(i_out_freq), .o_drive(o_drive), .o_state(o_state));
`default_nettype wire

// ==== testbench/power_stage_model.sv ====
// Power stage model: output frequency follows the sequencer requests
`default_nettype none
module power_stage_model (
  // Clock
  input wire logic i_mclk,
  // Sequencer side
  input wire logic [brake_seq_pkg::FREQ_W-1:0] i_freq_cmd,
  input wire brake_seq_pkg::drive_out_t i_drive,
  // Reported output frequency
  output logic [brake_seq_pkg::FREQ_W-1:0] o_out_freq
);
  timeunit 1ns;
  timeprecision 1ns;
  import brake_seq_pkg::*;
  logic [FREQ_W-1:0] freq_q = 16'h0000;
  // Cut output reads as zero at once; a coasting rotor is not reported back
  always @(posedge i_mclk)
  begin
    if (i_drive.decel)
      freq_q <= (freq_q > 16'h0032) ? freq_q - 16'h0032 : 16'h0000;
    else if (i_drive.run_normal)
      freq_q <= i_freq_cmd;
    else if (!i_drive.output_en)
      freq_q <= 16'h0000;
  end
  assign o_out_freq = freq_q;
endmodule : power_stage_model
`default_nettype wire

// ==== testbench/start_stop_braking_sequencer_test.sv ====
// Self-checking bench for the start/stop braking sequencer
`default_nettype none
module start_stop_braking_sequencer_test;
  timeunit 1ns;
  timeprecision 1ns;
  import brake_seq_pkg::*;
  localparam int TK = 8;
  logic i_mclk = 1'b0;
  logic i_rst = 1'b1;
  logic run = 1'b0;
  logic coast = 1'b0;
  drive_cfg_t cfg = '0;
  logic [FREQ_W-1:0] fcmd = 16'h01F4;
  logic [FREQ_W-1:0] ofreq;
  drive_out_t drv;
  seq_state_t st;
  int err_total = 0;
  int n_checks = 0;
  int ticks = 0;
  always #50 i_mclk = ~i_mclk;
  start_stop_braking_sequencer #(.TICK_CYCLES(TK)) dut_u (
    .i_mclk(i_mclk), .i_rst(i_rst), .i_run_cmd(run), .i_coast_stop_input(coast), .i_cfg(cfg),
    .i_freq_cmd(fcmd), .i_out_freq(ofreq), .o_drive(drv), .o_state(st));
  power_stage_model model_u (.i_mclk(i_mclk), .i_freq_cmd(fcmd), .i_drive(drv), .o_out_freq(ofreq));
  // ****************
  // Tasks
  // ****************
  task automatic summarize;
    $display("Checks %0d, errors %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  task automatic cyc(input int n);
    repeat (n) @(negedge i_mclk);
  endtask : cyc
  task automatic chk_st(input seq_state_t e);
    n_checks++;
    if (st !== e)
    begin
      err_total++;
      $display("Error %0t: state %0d, expected %0d", $time, st, e);
    end
  endtask : chk_st
  task automatic chk_v(input logic [1:0] g, input logic [1:0] e);
    n_checks++;
    if (g !== e)
    begin
      err_total++;
      $display("Error %0t: value %0h, expected %0h", $time, g, e);
    end
  endtask : chk_v
  task automatic wait_st(input seq_state_t e);
    int k;
    k = 0;
    while (st !== e && k < 400)
    begin
      cyc(1);
      k++;
    end
    chk_st(e);
  endtask : wait_st
  function automatic logic lockable(input drive_cfg_t c);
    return (c.brake_type_sel == BRK_MODE_SPEED && c.control_method_sel inside {METHOD_SLV_ZERO, METHOD_VEC_SENSOR})
      || (c.brake_type_sel == BRK_MODE_POS && c.control_method_sel == METHOD_VEC_SENSOR);
  endfunction : lockable
  function automatic logic brk_on(input drive_cfg_t c, input logic [DUR_W-1:0] d);
    return c.internal_brake_sel == BRK_SEL_ON && d != 0 && c.brake_force_pct != FORCE_NONE;
  endfunction : brk_on
  task automatic run_stop(input logic el, input logic eb);
    logic seen;
    int k;
    seen = 1'b0;
    k = 0;
    run = 1'b1;
    cyc(7);
    chk_st(el ? ST_START_LOCK : ST_RUN);
    if (el)
      chk_v({1'b0, drv.lock_position}, {1'b0, cfg.brake_type_sel == BRK_MODE_POS});
    wait_st(ST_RUN);
    chk_v({drv.run_normal, drv.servo_lock}, 2'h2);
    run = 1'b0;
    while (st !== ST_IDLE && k < 400)
    begin
      cyc(1);
      seen |= (st === ST_STOP_BRAKE);
      k++;
    end
    chk_v({1'b0, seen}, {1'b0, eb});
    chk_st(ST_IDLE);
    cyc(2);
  endtask : run_stop
  // ****************
  // Main sequence
  // ****************
  initial
  begin
    cfg.brake_threshold_freq = 16'h0064;
    cyc(2);
    i_rst = 1'b0;
    void'($urandom(32'h79afb7d9));
    // The first six runs pin down speed lock on 09, position lock on 10, zero force and fallbacks
    for (int i = 0; i < 12; i++)
    begin
      cfg.internal_brake_sel = (i < 6) ? BRK_SEL_ON : 2'($urandom_range(2));
      cfg.brake_type_sel = (i < 6) ? 2'(i % 3) : 2'($urandom_range(2));
      cfg.control_method_sel = (i < 6) ? 8'(8 + (i + i / 3) % 3) : 8'($urandom_range(10, 8));
      cfg.start_brake_duration = 10'($urandom_range(3, i < 6));
      cfg.stop_brake_duration = 10'($urandom_range(1));
      cfg.brake_force_pct = (i == 4) ? FORCE_NONE : 7'($urandom_range(100, 1));
      run_stop(brk_on(cfg, cfg.start_brake_duration) && lockable(cfg),
        brk_on(cfg, cfg.stop_brake_duration) && !lockable(cfg));
    end
    $display("Done: start lock and stop braking");
    cfg.internal_brake_sel = BRK_SEL_OFF;
    cfg.stop_method_sel = STOP_COAST;
    for (int r = 0; r < 3; r++)
    begin
      cfg.restart_after_coast_sel = 2'(r);
      run = 1'b1;
      wait_st(ST_RUN);
      run = 1'b0;
      wait_st(ST_COAST);
      chk_v({1'b0, drv.output_en}, 2'h0);
      wait_st(ST_IDLE);
      run = 1'b1;
      wait_st(ST_RUN);
      chk_v(drv.restart_mode, 2'(r));
      run = 1'b0;
      wait_st(ST_IDLE);
    end
    cfg.stop_method_sel = STOP_DECEL;
    run = 1'b1;
    wait_st(ST_RUN);
    coast = 1'b1;
    wait_st(ST_COAST);
    cyc(20);
    chk_st(ST_COAST);
    coast = 1'b0;
    wait_st(ST_RUN);
    chk_v(drv.restart_mode, RESTART_PULLIN);
    run = 1'b0;
    wait_st(ST_IDLE);
    $display("Done: free-run stops");
    cfg.internal_brake_sel = BRK_SEL_FREQ;
    cfg.brake_type_sel = BRK_MODE_SPEED;
    cfg.stop_brake_duration = 10'h002;
    cfg.brake_force_pct = 7'h3C;
    run = 1'b1;
    wait_st(ST_RUN);
    fcmd = 16'($urandom_range(100));
    wait_st(ST_FREQ_BRAKE);
    chk_v({drv.dc_brake, drv.carrier_reduce}, 2'h3);
    wait_st(ST_RUN);
    fcmd = 16'h01F4;
    run = 1'b0;
    wait_st(ST_IDLE);
    $display("Done: frequency braking");
    summarize();
  end
  always @(posedge i_mclk)
  begin
    ticks++;
    if (ticks == 20000)
    begin
      err_total++;
      summarize();
    end
  end
endmodule : start_stop_braking_sequencer_test
`default_nettype wire
